// ### rtl/bodr_alu.sv
`timescale 1ns/10ps
module bodr_alu (
  // operands
  input bodr_pkg::bodr_op_t i_op,
  input wire logic [7:0] i_accum,
  input wire logic [7:0] i_file,
  input wire logic i_carry,
  // result and flag updates
  output bodr_pkg::bodr_alu_t o_alu
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    o_alu = '0;
    case (i_op)
      bodr_pkg::OP_ADD, bodr_pkg::OP_ADDC: begin
        sum = {1'b0, i_accum} + {1'b0, i_file}
          + {8'h00, i_carry && i_op == bodr_pkg::OP_ADDC};
        nib = {1'b0, i_accum[3:0]} + {1'b0, i_file[3:0]}
          + {4'h0, i_carry && i_op == bodr_pkg::OP_ADDC};
        o_alu.res = sum[7:0];
        o_alu.c = sum[8];
        o_alu.dc = nib[4];
        {o_alu.wr_c, o_alu.wr_dc, o_alu.wr_z} = 3'b111; // [RULE7]
      end
      bodr_pkg::OP_AND: begin
        o_alu.res = i_accum & i_file;
        o_alu.wr_z = 1'b1; // [RULE8]
      end
      bodr_pkg::OP_IOR: begin
        o_alu.res = i_accum | i_file;
        o_alu.wr_z = 1'b1; // [RULE8]
      end
      bodr_pkg::OP_COM: begin
        o_alu.res = ~i_file;
        o_alu.wr_z = 1'b1; // [RULE8]
      end
      bodr_pkg::OP_ASR: begin
        o_alu.res = {i_file[7], i_file[7:1]};
        o_alu.c = i_file[0];
        {o_alu.wr_c, o_alu.wr_z} = 2'b11; // [RULE9]
      end
      bodr_pkg::OP_LSL: begin
        o_alu.res = {i_file[6:0], 1'b0};
        o_alu.c = i_file[7];
        {o_alu.wr_c, o_alu.wr_z} = 2'b11; // [RULE9]
      end
      bodr_pkg::OP_LSR: begin
        o_alu.res = {1'b0, i_file[7:1]};
        o_alu.c = i_file[0];
        {o_alu.wr_c, o_alu.wr_z} = 2'b11; // [RULE9]
      end
      bodr_pkg::OP_RLC: begin
        o_alu.res = {i_file[6:0], i_carry};
        o_alu.c = i_file[7];
        o_alu.wr_c = 1'b1; // [RULE10]
      end
      bodr_pkg::OP_RRC: begin
        o_alu.res = {i_carry, i_file[7:1]};
        o_alu.c = i_file[0];
        o_alu.wr_c = 1'b1; // [RULE10]
      end
      bodr_pkg::OP_CLR: begin
        o_alu.res = 8'h00;
        o_alu.wr_z = 1'b1;
      end
      bodr_pkg::OP_DEC: begin
        o_alu.res = i_file - 8'h01;
        o_alu.wr_z = 1'b1;
      end
      bodr_pkg::OP_INC: begin
        o_alu.res = i_file + 8'h01;
        o_alu.wr_z = 1'b1;
      end
      bodr_pkg::OP_MOV: begin
        o_alu.res = i_file;
        o_alu.wr_z = 1'b1;
      end
      bodr_pkg::OP_STW: o_alu.res = i_accum;
      default: o_alu.res = i_file;
    endcase
    o_alu.z = (o_alu.res == 8'h00);
  end
endmodule : bodr_alu

// ### rtl/bodr_core.sv
// What this block does
// RULE1: file operands run read, modify, then store
// RULE2: addressed register is read even when only written
// RULE3: destination bit picks accumulator or file register
// RULE4: seven-bit file address covers 0x00 to 0x7f
// RULE5: bit field selects one of eight bits
// RULE6: one accumulator is operand and alternative destination
// RULE7: add and add-with-carry set carry, digit carry, zero
// RULE8: and, or, complement touch only zero flag
// RULE9: shifts update carry and zero flags
// RULE10: rotates through carry change only carry
// RULE11: decoder ignores don't-care opcode bits
// RULE12: instruction word is fourteen bits, opcode plus operands
// RULE13: one instruction cycle spans four clock phases
// RULE14: unaffected flags keep their previous values
`timescale 1ns/10ps
module bodr_core #(
  parameter int RDCNT_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // file read side-effect strobe
  output logic o_file_rd,
  output logic [6:0] o_file_rd_addr,
  // execution status
  output logic o_busy
);
  if (RDCNT_W < 1 || RDCNT_W > 32) begin : g_chk
    $error("RDCNT_W must lie between 1 and 32");
  end

  typedef struct packed {
    bodr_pkg::bodr_state_t st;
    logic [13:0] ir;
    logic [7:0] accum;
    bodr_pkg::bodr_flags_t fl;
    logic [7:0] opnd;
    bodr_pkg::bodr_alu_t alu;
    logic [RDCNT_W-1:0] rdcnt;
    logic rd;
    logic [6:0] rd_addr;
    logic ack;
    logic err;
    logic [31:0] prdata;
    logic [bodr_pkg::FILE_DEPTH-1:0][7:0] file;
  } bodr_core_state_t;

  bodr_core_state_t s;
  bodr_core_state_t next_s;
  bodr_pkg::bodr_dec_t dec;
  logic [7:0] bit_mask;
  bodr_pkg::bodr_alu_t alu;

  bodr_decode u_decode (
    .i_instr(s.ir),
    .o_dec(dec),
    .o_bit_mask(bit_mask)
  );

  bodr_alu u_alu (
    .i_op(dec.op),
    .i_accum(s.accum),
    .i_file(s.opnd),
    .i_carry(s.fl.c),
    .o_alu(alu)
  );

  function automatic logic addr_ok(input logic [11:0] a);
    if (a[1:0] != 2'b00) begin
      return 1'b0;
    end else if (a == bodr_pkg::REG_INSTR || a == bodr_pkg::REG_ACCUM) begin
      return 1'b1;
    end else if (a == bodr_pkg::REG_STATUS || a == bodr_pkg::REG_DECODE) begin
      return 1'b1;
    end else if (a == bodr_pkg::REG_RDCNT) begin
      return 1'b1;
    end else if (a >= bodr_pkg::FILE_BASE && a <= bodr_pkg::FILE_LAST) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_ok

  always_comb begin
    next_s = s;
    next_s.rd = 1'b0;
    next_s.ack = 1'b0;
    // one wait state when idle, more while an instruction runs: read data and error are registered on the same edge as pready
    if (i_psel && i_penable && !s.ack && s.st == bodr_pkg::ST_IDLE) begin
      next_s.ack = 1'b1;
      next_s.err = !addr_ok(i_paddr);
      next_s.prdata = 32'h0000_0000;
      if (i_paddr == bodr_pkg::REG_INSTR) begin
        next_s.prdata = {18'h00000, s.ir};
      end else if (i_paddr == bodr_pkg::REG_ACCUM) begin
        next_s.prdata = {24'h000000, s.accum};
      end else if (i_paddr == bodr_pkg::REG_STATUS) begin
        next_s.prdata[bodr_pkg::STAT_C] = s.fl.c;
        next_s.prdata[bodr_pkg::STAT_DC] = s.fl.dc;
        next_s.prdata[bodr_pkg::STAT_Z] = s.fl.z;
        next_s.prdata[bodr_pkg::STAT_ILL] = s.fl.ill;
      end else if (i_paddr == bodr_pkg::REG_DECODE) begin
        next_s.prdata = {8'h00, bit_mask, 3'h0, dec.legal, dec.op,
          dec.dest, dec.faddr};
      end else if (i_paddr == bodr_pkg::REG_RDCNT) begin
        next_s.prdata = 32'(s.rdcnt);
      end else if (addr_ok(i_paddr)) begin
        next_s.prdata = {24'h000000, s.file[i_paddr[8:2]]};
      end
    end
    if (i_psel && i_penable && s.ack && i_pwrite && !s.err) begin
      if (i_paddr == bodr_pkg::REG_INSTR) begin
        next_s.ir = i_pwdata[13:0]; // [RULE12]
        next_s.st = bodr_pkg::ST_Q1;
      end else if (i_paddr == bodr_pkg::REG_ACCUM) begin
        next_s.accum = i_pwdata[7:0];
      end else if (i_paddr == bodr_pkg::REG_STATUS) begin
        next_s.fl.c = i_pwdata[bodr_pkg::STAT_C];
        next_s.fl.dc = i_pwdata[bodr_pkg::STAT_DC];
        next_s.fl.z = i_pwdata[bodr_pkg::STAT_Z];
        if (i_pwdata[bodr_pkg::STAT_ILL]) begin
          next_s.fl.ill = 1'b0;
        end
      end else if (i_paddr >= bodr_pkg::FILE_BASE) begin
        next_s.file[i_paddr[8:2]] = i_pwdata[7:0];
      end
    end
    // four phases: decode, read, modify, write back
    case (s.st)
      bodr_pkg::ST_Q1: begin
        if (dec.legal) begin
          next_s.st = bodr_pkg::ST_Q2; // [RULE13]
        end else begin
          next_s.fl.ill = 1'b1;
          next_s.st = bodr_pkg::ST_IDLE;
        end
      end
      bodr_pkg::ST_Q2: begin
        // read happens for every file form, including pure writes
        next_s.opnd = s.file[dec.faddr]; // [RULE1] [RULE2] [RULE4]
        next_s.rd = 1'b1; // [RULE2]
        next_s.rd_addr = dec.faddr;
        next_s.rdcnt = s.rdcnt + RDCNT_W'(1);
        next_s.st = bodr_pkg::ST_Q3;
      end
      bodr_pkg::ST_Q3: begin
        next_s.alu = alu; // [RULE1]
        next_s.st = bodr_pkg::ST_Q4;
      end
      bodr_pkg::ST_Q4: begin
        if (dec.dest) begin // [RULE3]
          next_s.file[dec.faddr] = s.alu.res;
        end else begin
          next_s.accum = s.alu.res; // [RULE6]
        end
        // flags without a write enable hold their value
        if (s.alu.wr_c) begin // [RULE14]
          next_s.fl.c = s.alu.c;
        end
        if (s.alu.wr_dc) begin // [RULE14]
          next_s.fl.dc = s.alu.dc;
        end
        if (s.alu.wr_z) begin // [RULE14]
          next_s.fl.z = s.alu.z;
        end
        next_s.st = bodr_pkg::ST_IDLE;
      end
      default: next_s.st = next_s.st;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
      s.st <= bodr_pkg::ST_IDLE;
      s.ir <= bodr_pkg::INSTR_RST;
      s.accum <= bodr_pkg::ACCUM_RST;
      s.file <= {bodr_pkg::FILE_DEPTH{bodr_pkg::FILE_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign o_prdata = s.prdata;
  assign o_pready = s.ack;
  assign o_pslverr = s.ack && s.err;
  assign o_file_rd = s.rd;
  assign o_file_rd_addr = s.rd_addr;
  assign o_busy = (s.st != bodr_pkg::ST_IDLE);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_rmw_walk;
    s.st == bodr_pkg::ST_Q2 ##1 (s.st == bodr_pkg::ST_Q3 && o_file_rd)
      ##1 s.st == bodr_pkg::ST_Q4 ##1 s.st == bodr_pkg::ST_IDLE;
  endsequence

  sequence s_legal_start;
    s.st == bodr_pkg::ST_Q1 && dec.legal;
  endsequence

  a_rmw_phase_order: assert property ( // [RULE1] [RULE13]
    s_legal_start |=> s_rmw_walk)
    else $error("read-modify-write phases out of order");

  a_store_still_reads: assert property ( // [RULE2]
    (s_legal_start and (dec.op == bodr_pkg::OP_STW)) |=> ##1 o_file_rd)
    else $error("store-only instruction skipped the file read");

  a_dest_accum_wb: assert property ( // [RULE3] [RULE6]
    s.st == bodr_pkg::ST_Q4 && !dec.dest |=> s.accum == $past(s.alu.res))
    else $error("accumulator not written with result");

  a_dest_file_wb: assert property ( // [RULE3]
    s.st == bodr_pkg::ST_Q4 && dec.dest
      |=> s.file[$past(dec.faddr)] == $past(s.alu.res)
        && s.accum == $past(s.accum))
    else $error("file register write-back wrong");

  a_read_addr_field: assert property ( // [RULE4]
    o_file_rd |-> o_file_rd_addr == s.ir[6:0]
      && s.opnd == s.file[s.ir[6:0]])
    else $error("file read used wrong address");

  a_bit_mask_onehot: assert property ( // [RULE5]
    bit_mask == (8'h01 << s.ir[9:7]) && $onehot(bit_mask))
    else $error("bit field decode not one-hot");

  a_add_flags_upd: assert property ( // [RULE7]
    s.st == bodr_pkg::ST_Q4 && dec.op inside {bodr_pkg::OP_ADD,
      bodr_pkg::OP_ADDC}
      |=> s.fl.c == $past(s.alu.c) && s.fl.dc == $past(s.alu.dc)
        && s.fl.z == ($past(s.alu.res) == 8'h00))
    else $error("add did not update carry, digit carry and zero");

  a_logic_keeps_c: assert property ( // [RULE8] [RULE14]
    s.st == bodr_pkg::ST_Q4 && dec.op inside {bodr_pkg::OP_AND,
      bodr_pkg::OP_IOR, bodr_pkg::OP_COM}
      |=> $stable(s.fl.c) && $stable(s.fl.dc))
    else $error("logic operation disturbed carry flags");

  a_lsl_carry_out: assert property ( // [RULE9]
    s.st == bodr_pkg::ST_Q3 && dec.op == bodr_pkg::OP_LSL
      |=> ##1 s.fl.c == $past(s.opnd[7], 2))
    else $error("left shift carry not bit seven");

  a_rotate_keeps_z: assert property ( // [RULE10] [RULE14]
    s.st == bodr_pkg::ST_Q4 && dec.op inside {bodr_pkg::OP_RLC,
      bodr_pkg::OP_RRC} |=> $stable(s.fl.z) && $stable(s.fl.dc))
    else $error("rotate changed zero or digit carry");

  a_clear_accum_dont_care: assert property ( // [RULE11]
    s.ir[13:2] == bodr_pkg::CLEAR_ACCUM_PATTERN
      |-> dec.legal && dec.op == bodr_pkg::OP_CLR && !dec.dest)
    else $error("clear-accumulator low bits not ignored");

  a_instr_load: assert property ( // [RULE12]
    i_psel && i_penable && o_pready && i_pwrite && !s.err
      && i_paddr == bodr_pkg::REG_INSTR
      |=> s.st == bodr_pkg::ST_Q1 && s.ir == $past(i_pwdata[13:0]))
    else $error("instruction word not loaded");

  a_addc_carry_in: assert property ( // [RULE7]
    s.st == bodr_pkg::ST_Q3 && dec.op == bodr_pkg::OP_ADDC
      |=> s.alu.res == 8'(s.accum + $past(s.opnd)
        + {7'h00, $past(s.fl.c)}))
    else $error("add with carry ignored the carry input");

  a_right_carry_out: assert property ( // [RULE9] [RULE10]
    s.st == bodr_pkg::ST_Q3 && dec.op inside {bodr_pkg::OP_ASR,
      bodr_pkg::OP_LSR, bodr_pkg::OP_RRC}
      |=> ##1 s.fl.c == $past(s.opnd[0], 2))
    else $error("right shift carry not bit zero");

  a_shift_zero_upd: assert property ( // [RULE9] [RULE14]
    s.st == bodr_pkg::ST_Q4 && dec.op inside {bodr_pkg::OP_ASR,
      bodr_pkg::OP_LSL, bodr_pkg::OP_LSR}
      |=> s.fl.z == ($past(s.alu.res) == 8'h00) && $stable(s.fl.dc))
    else $error("shift zero or digit carry flag wrong");

  a_logic_zero_upd: assert property ( // [RULE8]
    s.st == bodr_pkg::ST_Q4 && dec.op inside {bodr_pkg::OP_AND,
      bodr_pkg::OP_IOR, bodr_pkg::OP_COM}
      |=> s.fl.z == ($past(s.alu.res) == 8'h00))
    else $error("logic operation zero flag wrong");

  a_store_no_flags: assert property ( // [RULE14]
    s.st == bodr_pkg::ST_Q4 && dec.op == bodr_pkg::OP_STW
      |=> $stable(s.fl))
    else $error("store accumulator changed a flag");

  a_accum_dest_file: assert property ( // [RULE3]
    s.st == bodr_pkg::ST_Q4 && !dec.dest
      |=> s.file[$past(dec.faddr)] == $past(s.file[dec.faddr]))
    else $error("file register written for accumulator destination");

  a_illegal_flagged: assert property ( // [RULE12]
    s.st == bodr_pkg::ST_Q1 && !dec.legal
      |=> s.fl.ill && s.st == bodr_pkg::ST_IDLE && !o_file_rd)
    else $error("malformed opcode not flagged");
endmodule : bodr_core

// ### rtl/bodr_decode.sv
`timescale 1ns/10ps
module bodr_decode (
  // instruction word
  input wire logic [13:0] i_instr,
  // decoded fields
  output bodr_pkg::bodr_dec_t o_dec,
  output logic [7:0] o_bit_mask
);
  function automatic bodr_pkg::bodr_dec_t decode(input logic [13:0] ir);
    bodr_pkg::bodr_dec_t d;
    d.op = bodr_pkg::OP_NONE;
    d.dest = ir[7];
    d.faddr = ir[6:0];
    d.bitpos = ir[9:7];
    d.legal = 1'b1;
    case (ir[13:8])
      6'b000111: d.op = bodr_pkg::OP_ADD; // [RULE7]
      6'b111101: d.op = bodr_pkg::OP_ADDC; // [RULE7]
      6'b000101: d.op = bodr_pkg::OP_AND; // [RULE8]
      6'b000100: d.op = bodr_pkg::OP_IOR; // [RULE8]
      6'b001001: d.op = bodr_pkg::OP_COM; // [RULE8]
      6'b110111: d.op = bodr_pkg::OP_ASR; // [RULE9]
      6'b110101: d.op = bodr_pkg::OP_LSL; // [RULE9]
      6'b110110: d.op = bodr_pkg::OP_LSR; // [RULE9]
      6'b001101: d.op = bodr_pkg::OP_RLC; // [RULE10]
      6'b001100: d.op = bodr_pkg::OP_RRC; // [RULE10]
      6'b000011: d.op = bodr_pkg::OP_DEC;
      6'b001010: d.op = bodr_pkg::OP_INC;
      6'b001000: d.op = bodr_pkg::OP_MOV;
      6'b000001: begin
        d.op = bodr_pkg::OP_CLR;
        // low two bits of the clear-accumulator form are ignored
        if (!ir[7] && ir[6:2] != 5'h00) begin // [RULE11]
          d.legal = 1'b0;
        end
      end
      6'b000000: begin
        d.op = bodr_pkg::OP_STW;
        d.legal = ir[7];
      end
      default: d.legal = 1'b0;
    endcase
    return d;
  endfunction : decode

  always_comb begin
    o_dec = decode(i_instr);
    o_bit_mask = 8'h01 << i_instr[9:7]; // [RULE5]
  end
endmodule : bodr_decode

// ### rtl/bodr_pkg.sv
package bodr_pkg;
  // apb register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_INSTR = 12'h000;
  localparam logic [11:0] REG_ACCUM = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_DECODE = 12'h00c;
  localparam logic [11:0] REG_RDCNT = 12'h010;
  localparam logic [11:0] FILE_BASE = 12'h200;
  localparam logic [11:0] FILE_LAST = 12'h3fc;
  // status bit positions
  localparam int STAT_C = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z = 2;
  localparam int STAT_BUSY = 3;
  localparam int STAT_ILL = 4;
  // reset values
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;
  // opcode geometry
  localparam int OP_W = 14;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [11:0] CLEAR_ACCUM_PATTERN = 12'h040;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1 = 3'b001,
    ST_Q2 = 3'b010,
    ST_Q3 = 3'b011,
    ST_Q4 = 3'b100
  } bodr_state_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_ADD = 4'b0001,
    OP_ADDC = 4'b0010,
    OP_AND = 4'b0011,
    OP_IOR = 4'b0100,
    OP_COM = 4'b0101,
    OP_ASR = 4'b0110,
    OP_LSL = 4'b0111,
    OP_LSR = 4'b1000,
    OP_RLC = 4'b1001,
    OP_RRC = 4'b1010,
    OP_CLR = 4'b1011,
    OP_DEC = 4'b1100,
    OP_INC = 4'b1101,
    OP_MOV = 4'b1110,
    OP_STW = 4'b1111
  } bodr_op_t;

  typedef struct packed {
    bodr_op_t op;
    logic dest;
    logic [6:0] faddr;
    logic [2:0] bitpos;
    logic legal;
  } bodr_dec_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
    logic wr_c;
    logic wr_dc;
    logic wr_z;
  } bodr_alu_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
    logic ill;
  } bodr_flags_t;
endpackage : bodr_pkg

// ### testbench/byte_op_decode_rmw_tb.sv
`timescale 1ns/10ps
module byte_op_decode_rmw_tb;
  typedef struct packed {
    logic rd;
    logic err;
    logic [31:0] d;
  } bodr_note_t;

  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_file_rd;
  logic [6:0] o_file_rd_addr;
  logic o_busy;
  int fail_count = 0;
  int tests_run = 0;
  bodr_note_t notes[$];
  bodr_note_t cur;
  logic [6:0] rd_addrs[$];
  logic [31:0] seed = 32'hbf89;
  logic [15:0] rdcnt_exp = 16'h0000;
  logic [5:0] ops [10] = '{6'h07, 6'h3d, 6'h05, 6'h04, 6'h09,
                           6'h37, 6'h35, 6'h36, 6'h0d, 6'h0c};

  always #5 i_core_clk = ~i_core_clk;

  bodr_core bodr_core_i (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_file_rd(o_file_rd),
    .o_file_rd_addr(o_file_rd_addr),
    .o_busy(o_busy)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  // result in [10:3], zero/digit carry/carry in [2:0]
  function automatic logic [10:0] model(input int k, input logic [7:0] a,
                                        input logic [7:0] v,
                                        input logic [2:0] s);
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] r;
    logic c;
    logic dc;
    c = s[0];
    dc = s[1];
    sum = {1'b0, a} + {1'b0, v} + ((k == 1) ? {8'h0, c} : 9'h0);
    lo = {1'b0, a[3:0]} + {1'b0, v[3:0]} + ((k == 1) ? {4'h0, c} : 5'h0);
    case (k)
      0, 1: begin
        r = sum[7:0];
        c = sum[8];
        dc = lo[4];
      end
      2: r = a & v;
      3: r = a | v;
      4: r = ~v;
      5: begin
        r = {v[7], v[7:1]};
        c = v[0];
      end
      6: begin
        r = {v[6:0], 1'b0};
        c = v[7];
      end
      7: begin
        r = {1'b0, v[7:1]};
        c = v[0];
      end
      8: begin
        r = {v[6:0], s[0]};
        c = v[7];
      end
      default: begin
        r = {s[0], v[7:1]};
        c = v[0];
      end
    endcase
    return {r, (k < 8) ? (r == 8'h00) : s[2], dc, c};
  endfunction : model

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic err,
                     input logic [31:0] exp);
    int n;
    notes.push_back('{!wr, err, exp});
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 40);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0, exp);
  endtask : rd

  task automatic exec(input logic [13:0] ir, input int busy_cyc,
                      input logic rdf);
    int n;
    if (rdf) begin
      rd_addrs.push_back(ir[6:0]);
      rdcnt_exp++;
    end
    wr(bodr_pkg::REG_INSTR, {18'h0, ir});
    n = 0;
    repeat (8) begin
      @(posedge i_core_clk);
      if (o_busy === 1'b1) n++;
    end
    check("busy_cycles", n, busy_cyc);
  endtask : exec

  // watcher: pairs each bus answer with its note and each file read with its queued address
  always @(posedge i_core_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      cur = notes.pop_front();
      check("pslverr", {31'h0, o_pslverr}, {31'h0, cur.err});
      if (cur.rd) check("prdata", o_prdata, cur.d);
    end
    if (o_file_rd === 1'b1) begin
      check("file_rd_addr", {25'h0, o_file_rd_addr},
            (rd_addrs.size() > 0) ? {25'h0, rd_addrs.pop_front()} : '1);
    end
  end

  initial begin
    logic [7:0] a;
    logic [7:0] fv;
    logic [2:0] st;
    logic [10:0] m;
    logic [6:0] f;
    logic d;
    logic [13:0] ir;
    logic [11:0] fa;
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    rd(bodr_pkg::REG_ACCUM, 32'h0);
    rd(bodr_pkg::REG_STATUS, 32'h0);
    rd(bodr_pkg::FILE_LAST, 32'h0);
    for (int it = 0; it < 4; it++) begin
      for (int k = 0; k < 10; k++) begin
        a = rnd();
        fv = rnd();
        st = 3'(rnd());
        f = (it == 0) ? 7'h7f : (it == 1) ? 7'h00 : 7'(rnd());
        d = 1'(rnd());
        ir = {ops[k], d, f};
        fa = bodr_pkg::FILE_BASE + {3'h0, f, 2'h0};
        m = model(k, a, fv, st);
        wr(fa, {24'h0, fv});
        wr(bodr_pkg::REG_ACCUM, {24'h0, a});
        wr(bodr_pkg::REG_STATUS, {29'h0, st});
        exec(ir, 4, 1'b1);
        rd(bodr_pkg::REG_ACCUM, {24'h0, d ? a : m[10:3]});
        rd(fa, {24'h0, d ? m[10:3] : fv});
        rd(bodr_pkg::REG_STATUS, {29'h0, m[2:0]});
        rd(bodr_pkg::REG_DECODE, {8'h0, 8'(1 << ir[9:7]), 3'h0, 1'b1,
                                  4'(k + 1), ir[7:0]});
      end
    end
    // store accumulator: write-only form still reads the file register
    a = rnd();
    st = 3'(rnd());
    wr(bodr_pkg::FILE_BASE + 12'h014, 32'h5a);
    wr(bodr_pkg::REG_ACCUM, {24'h0, a});
    wr(bodr_pkg::REG_STATUS, {29'h0, st});
    exec(14'h0085, 4, 1'b1);
    rd(bodr_pkg::FILE_BASE + 12'h014, {24'h0, a});
    rd(bodr_pkg::REG_STATUS, {29'h0, st});
    rd(bodr_pkg::REG_RDCNT, {16'h0, rdcnt_exp});
    // clear accumulator with both don't-care bits set
    exec(14'h0103, 4, 1'b1);
    rd(bodr_pkg::REG_ACCUM, 32'h0);
    rd(bodr_pkg::REG_STATUS, {29'h0, 1'b1, st[1:0]});
    // malformed clear: flagged, no file read, nothing else moves
    exec(14'h0104, 1, 1'b0);
    rd(bodr_pkg::REG_STATUS, {27'h0, 2'b10, 1'b1, st[1:0]});
    rd(bodr_pkg::REG_RDCNT, {16'h0, rdcnt_exp});
    wr(bodr_pkg::REG_STATUS, 32'h10);
    rd(bodr_pkg::REG_STATUS, 32'h0);
    // unmapped and misaligned accesses
    apb(1'b0, 12'h014, 32'h0, 1'b1, 32'h0);
    apb(1'b1, 12'h006, 32'h55, 1'b1, 32'h0);
    rd(bodr_pkg::REG_ACCUM, 32'h0);
    results();
  end
endmodule : byte_op_decode_rmw_tb
